/* src/dmsp_top.sv */
// Serial port of the displacement meter: FIFO for measurement bytes and the port itself.
// Assumes synchronous pins, one clock and a software master on the plain register port.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Measurement byte FIFO
// ****************************************
module dmsp_fifo import dmsp_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("FIFO depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} dmsp_fifo_st_t;

	dmsp_fifo_st_t s_q, s_d;
	logic push, pop;

	assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data = s_q.mem[s_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	chk_fifo_no_wrap: assert property (@(posedge ref_clk) disable iff (reset)
		s_q.cnt <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule // dmsp_fifo

// ****************************************
// Serial port
// ****************************************
module dmsp_top import dmsp_pkg::*; #(
	parameter int CLK_HZ = CLK_HZ_DEF,
	parameter int BASE_BAUD = BASE_BAUD_DEF,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire dmsp_req_t reg_req,
	output logic [31:0] reg_rdata,
	// Unit straps
	input wire logic standalone_in,
	input wire logic [3:0] baud_dial_in,
	// Serial link
	input wire logic rxd_in,
	output logic txd_out,
	input wire logic dtr_in,
	output logic cts_out,
	output logic dsr_out,
	output logic dcd_out
);
	localparam int BASE_DIV = CLK_HZ / BASE_BAUD;
	localparam int CW = $clog2(BASE_DIV + 1);

	if ((BASE_DIV >> 8) < 4) begin : g_chk
		$error("Clock too slow for the fastest baud rate");
	end

	typedef struct packed {
		dmsp_frame_t ctrl;
		logic [31:0] rdata;
		logic txd;
		dmsp_bit_t tx_st;
		logic [CW-1:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_par;
		logic [2:0] ack_idx;
		dmsp_bit_t rx_st;
		logic [CW-1:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_par;
		logic [7:0] set_ch;
		logic set_fresh;
		logic par_err;
		logic frm_err;
	} dmsp_state_t;

	function automatic logic [CW-1:0] baud_div(input logic [3:0] sel);
		// Positions above the top one repeat the fastest rate
		baud_div = (sel > BAUD_TOP_SEL) ? CW'(BASE_DIV >> BAUD_TOP_SEL) : CW'(BASE_DIV >> sel);
	endfunction

	function automatic logic is_setting(input logic [7:0] c);
		is_setting = (c >= SET_LO_A && c <= SET_HI_A) || (c >= SET_LO_B && c <= SET_HI_B);
	endfunction

	dmsp_state_t s_q, s_d;
	dmsp_frame_t fr;
	logic [CW-1:0] div;
	logic [2:0] last_bit;
	logic fifo_push, fifo_ready, fifo_valid, fifo_pop;
	logic [7:0] fifo_data;
	logic [7:0] rx_ch;
	logic rx_end, rx_good;

	assign fr = standalone_in ? {FIXED_FRAME[7:4], baud_dial_in} : s_q.ctrl; // [RULE8]
	assign div = baud_div(fr.baud); // [RULE9] [RULE7]
	assign last_bit = fr.eight ? 3'h7 : 3'h6;
	assign fifo_push = reg_req.wr && reg_req.addr == OFS_TXDATA;
	// Acknowledgements go ahead of queued measurement bytes
	assign fifo_pop = s_q.tx_st == BIT_IDLE && s_q.ack_idx == ACK_LEN
		&& dtr_in && fifo_valid; // [RULE5] [RULE6]
	assign rx_ch = fr.eight ? s_q.rx_sh : {1'b0, s_q.rx_sh[7:1]};
	assign rx_end = s_q.rx_st == BIT_STOP && s_q.rx_cnt == '0;
	assign rx_good = rx_end && rxd_in
		&& (!fr.par_en || (^rx_ch ^ s_q.rx_par ^ fr.par_odd) == 1'b0);

	assign txd_out = s_q.txd;
	assign reg_rdata = s_q.rdata;
	assign cts_out = 1'b1; // [RULE4]
	assign dsr_out = 1'b1; // [RULE4]
	assign dcd_out = 1'b1; // [RULE4]

	dmsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(fifo_push),
		.in_ready(fifo_ready),
		.in_data(reg_req.wdata[7:0]),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	always_comb begin
		s_d = s_q;
		// ****************************************
		// Register port
		// ****************************************
		s_d.rdata = '0;
		if (reg_req.rd) begin
			case (reg_req.addr)
				OFS_CTRL: s_d.rdata = {24'h0, s_q.ctrl};
				OFS_RXSET: s_d.rdata = {23'h0, s_q.set_fresh, s_q.set_ch};
				OFS_STATUS: s_d.rdata = {26'h0, dtr_in, s_q.frm_err, s_q.par_err,
					s_q.tx_st != BIT_IDLE, !fifo_valid, !fifo_ready};
				default: s_d.rdata = '0;
			endcase
			if (reg_req.addr == OFS_RXSET) begin
				s_d.set_fresh = 1'b0;
			end
		end
		if (reg_req.wr && reg_req.addr == OFS_CTRL) begin
			s_d.ctrl = reg_req.wdata[7:0];
		end
		if (reg_req.wr && reg_req.addr == OFS_STATUS) begin
			s_d.par_err = s_q.par_err && !reg_req.wdata[ST_PAR_ERR];
			s_d.frm_err = s_q.frm_err && !reg_req.wdata[ST_FRM_ERR];
		end
		// ****************************************
		// Transmitter
		// ****************************************
		s_d.tx_cnt = (s_q.tx_cnt == '0) ? div - 1'b1 : s_q.tx_cnt - 1'b1;
		case (s_q.tx_st)
			BIT_IDLE: begin
				s_d.txd = 1'b1; // [RULE1]
				if (s_q.ack_idx != ACK_LEN || fifo_pop) begin
					s_d.tx_sh = fifo_pop ? fifo_data
						: ACK_TEXT[(ACK_LEN - 3'h1 - s_q.ack_idx)*8 +: 8]; // [RULE10]
					s_d.ack_idx = fifo_pop ? s_q.ack_idx : s_q.ack_idx + 3'h1;
					s_d.tx_par = ^(fr.eight ? s_d.tx_sh : {1'b0, s_d.tx_sh[6:0]}) ^ fr.par_odd;
					s_d.tx_st = BIT_START;
					s_d.txd = 1'b0; // [RULE2]
					s_d.tx_cnt = div - 1'b1;
				end
			end
			BIT_START: begin
				if (s_q.tx_cnt == '0) begin
					s_d.tx_st = BIT_DATA;
					s_d.txd = s_q.tx_sh[0];
					s_d.tx_bit = 3'h0;
				end
			end
			BIT_DATA: begin
				if (s_q.tx_cnt == '0) begin
					s_d.tx_sh = s_q.tx_sh >> 1;
					s_d.tx_bit = s_q.tx_bit + 3'h1;
					s_d.txd = s_q.tx_sh[1];
					if (s_q.tx_bit == last_bit) begin
						s_d.tx_st = fr.par_en ? BIT_PAR : BIT_STOP; // [RULE7]
						s_d.txd = fr.par_en ? s_q.tx_par : 1'b1;
						s_d.tx_bit = 3'h0;
					end
				end
			end
			BIT_PAR: begin
				if (s_q.tx_cnt == '0) begin
					s_d.tx_st = BIT_STOP;
					s_d.txd = 1'b1;
				end
			end
			BIT_STOP: begin
				if (s_q.tx_cnt == '0) begin
					s_d.tx_bit = 3'h1;
					if (!fr.stop2 || s_q.tx_bit != 3'h0) begin
						s_d.tx_st = BIT_IDLE; // [RULE7]
					end
				end
			end
			default: begin
				s_d.tx_st = BIT_IDLE;
				s_d.txd = 1'b1;
			end
		endcase
		// ****************************************
		// Receiver
		// ****************************************
		s_d.rx_cnt = (s_q.rx_cnt == '0) ? div - 1'b1 : s_q.rx_cnt - 1'b1;
		case (s_q.rx_st)
			BIT_IDLE: begin
				if (!rxd_in) begin
					s_d.rx_st = BIT_START;
					s_d.rx_cnt = div >> 1;
				end
			end
			BIT_START: begin
				// A start bit gone high by mid-bit is a glitch, not a frame
				if (s_q.rx_cnt == '0) begin
					s_d.rx_st = rxd_in ? BIT_IDLE : BIT_DATA;
					s_d.rx_bit = 3'h0;
				end
			end
			BIT_DATA: begin
				if (s_q.rx_cnt == '0) begin
					s_d.rx_sh = {rxd_in, s_q.rx_sh[7:1]};
					s_d.rx_bit = s_q.rx_bit + 3'h1;
					if (s_q.rx_bit == last_bit) begin
						s_d.rx_st = fr.par_en ? BIT_PAR : BIT_STOP;
					end
				end
			end
			BIT_PAR: begin
				if (s_q.rx_cnt == '0) begin
					s_d.rx_par = rxd_in;
					s_d.rx_st = BIT_STOP;
				end
			end
			BIT_STOP: begin
				// Only the first stop bit is checked so the next start is not missed
				if (s_q.rx_cnt == '0) begin
					s_d.rx_st = BIT_IDLE;
				end
			end
			default: s_d.rx_st = BIT_IDLE;
		endcase
		// Hardware set wins over a software clear in the same cycle
		if (rx_end && !rxd_in) begin
			s_d.frm_err = 1'b1;
		end else if (rx_end && !rx_good) begin
			s_d.par_err = 1'b1;
		end
		if (rx_good) begin
			s_d.set_ch = rx_ch; // [RULE3]
			s_d.set_fresh = 1'b1;
			if (is_setting(rx_ch)) begin
				s_d.ack_idx = 3'h0; // [RULE10]
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_q <= '{ctrl: CTRL_RESET, txd: 1'b1, tx_st: BIT_IDLE, ack_idx: ACK_LEN,
				rx_st: BIT_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	chk_modem_lines_on: assert property (@(posedge ref_clk) disable iff (reset) // [RULE4]
		cts_out && dsr_out && dcd_out) else $error("Modem status line low");
	chk_idle_mark: assert property (@(posedge ref_clk) disable iff (reset) // [RULE1]
		s_q.tx_st == BIT_IDLE |-> txd_out) else $error("Transmit line low while idle");
	chk_start_bit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
		s_q.tx_st == BIT_IDLE && s_d.tx_st == BIT_START |=> !txd_out [*2])
		else $error("No start bit after leaving idle");
	chk_dtr_gate: assert property (@(posedge ref_clk) disable iff (reset) // [RULE5]
		s_q.tx_st == BIT_IDLE && s_q.ack_idx == ACK_LEN && !dtr_in |=> s_q.tx_st == BIT_IDLE)
		else $error("Measurement byte sent without terminal ready");
	chk_fixed_frame: assert property (@(posedge ref_clk) disable iff (reset) // [RULE8]
		standalone_in |-> fr.eight && !fr.par_en && !fr.stop2 && fr.baud == baud_dial_in)
		else $error("Standalone frame not 8N1");
	chk_top_baud: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
		fr.baud >= BAUD_TOP_SEL |-> div == CW'(BASE_DIV >> 8)) else $error("Top baud wrong");
	chk_stop_mark: assert property (@(posedge ref_clk) disable iff (reset) // [RULE7]
		s_q.tx_st == BIT_STOP |-> txd_out) else $error("Stop bit not high");
	chk_rx_capture: assert property (@(posedge ref_clk) disable iff (reset) // [RULE3]
		rx_good |=> s_q.set_fresh && s_q.set_ch == $past(rx_ch)) else $error("Char not kept");
	chk_ack_start: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
		rx_good && is_setting(rx_ch) |=> s_q.ack_idx == 3'h0 ##1 s_q.tx_st == BIT_START
		|| $past(s_q.tx_st) != BIT_IDLE) else $error("Setting char not acknowledged");
endmodule // dmsp_top

`default_nettype wire

/* src/dmsp_pkg.sv */
// Constants and types shared by the displacement meter serial port.
// Assumes a single 100 MHz clock and a plain register port on the software side.
// How it works
// RULE1 - The port is the data-communication end of a full-duplex start-stop link with mark-high idle.
// RULE2 - Measurement bytes leave on the transmit pin and setting characters arrive on the receive pin.
// RULE3 - When running without the display unit, received characters are handed to software as parameter settings.
// RULE4 - Clear-to-send, data-set-ready and carrier-detect are driven high at all times while powered.
// RULE5 - Measurement bytes are sent only while the host holds data-terminal-ready high.
// RULE6 - An open data-terminal-ready line reads high because of the pull-up, so output then proceeds.
// RULE7 - A frame is a start bit, 7 or 8 data bits, optional even or odd parity, and 1 or 2 stop bits, at 75 to 19200 baud in doubling steps.
// RULE8 - A control unit on its own uses 8 data bits, no parity and 1 stop bit; only the baud rate changes.
// RULE9 - Selector positions 0 to 9 give 75 up to 19200 baud, with positions 8 and 9 both 19200.
// RULE10 - A valid setting character is answered with an acknowledgement ending in carriage return; output requests are not.
package dmsp_pkg;

	// ****************************************
	// Register map and layout
	// ****************************************
	localparam logic [1:0] OFS_CTRL = 2'h0;
	localparam logic [1:0] OFS_TXDATA = 2'h1;
	localparam logic [1:0] OFS_RXSET = 2'h2;
	localparam logic [1:0] OFS_STATUS = 2'h3;

	localparam int RXSET_FRESH = 8;
	localparam int ST_FULL = 0;
	localparam int ST_EMPTY = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_PAR_ERR = 3;
	localparam int ST_FRM_ERR = 4;
	localparam int ST_DTR = 5;

	typedef struct packed {
		logic stop2;
		logic par_odd;
		logic par_en;
		logic eight;
		logic [3:0] baud;
	} dmsp_frame_t;

	// 1200 baud, 8 data bits, no parity, 1 stop bit
	localparam dmsp_frame_t CTRL_RESET = 8'h14;
	localparam dmsp_frame_t FIXED_FRAME = 8'h10;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] addr;
		logic [31:0] wdata;
	} dmsp_req_t;

	// ****************************************
	// Timing and characters
	// ****************************************
	localparam int CLK_HZ_DEF = 100_000_000;
	localparam int BASE_BAUD_DEF = 75;
	localparam logic [3:0] BAUD_TOP_SEL = 4'h8;

	typedef enum logic [2:0] {
		BIT_IDLE = 3'h0,
		BIT_START = 3'h1,
		BIT_DATA = 3'h3,
		BIT_PAR = 3'h2,
		BIT_STOP = 3'h6
	} dmsp_bit_t;

	localparam logic [2:0] ACK_LEN = 3'h5;
	localparam logic [39:0] ACK_TEXT = {8'h50, 8'h41, 8'h53, 8'h53, 8'h0D};
	localparam logic [7:0] SET_LO_A = 8'h20;
	localparam logic [7:0] SET_HI_A = 8'h4A;
	localparam logic [7:0] SET_LO_B = 8'h65;
	localparam logic [7:0] SET_HI_B = 8'h68;

endpackage

/* dv/dmsp_host_model.sv */
// Host computer partner: decodes the meter's transmit line and sends characters.
// Assumes the bench sets bit period and frame fields while the link is idle.
`timescale 1ns/1ps
`default_nettype none

module dmsp_host_model (
	// Clock
	input wire logic ref_clk,
	// Frame settings
	input wire logic [15:0] div,
	input wire logic eight,
	input wire logic par_en,
	input wire logic par_odd,
	input wire logic stop2,
	// Serial lines
	input wire logic txd,
	output logic rxd
);
	// Entries are {stop_ok, parity, data}
	logic [9:0] rx_q[$];
	logic [7:0] dat;
	logic par;
	int nb;

	// Mark level while idle
	initial rxd = 1'b1;

	// Samples mid-cycle so the design's edge never races the decode
	always begin
		@(negedge ref_clk);
		if (txd === 1'b0) begin
			repeat (div / 2) @(negedge ref_clk);
			if (txd === 1'b0) begin
				nb = eight ? 8 : 7;
				dat = 8'h00;
				par = 1'b0;
				for (int i = 0; i < nb; i++) begin
					repeat (div) @(negedge ref_clk);
					dat[i] = txd;
				end
				if (par_en) begin
					repeat (div) @(negedge ref_clk);
					par = txd;
				end
				repeat (div) @(negedge ref_clk);
				rx_q.push_back({txd === 1'b1, par, dat});
			end
		end
	end

	task automatic send_char(input logic [7:0] c);
		@(posedge ref_clk);
		rxd <= 1'b0;
		repeat (div) @(posedge ref_clk);
		for (int i = 0; i < (eight ? 8 : 7); i++) begin
			rxd <= c[i];
			repeat (div) @(posedge ref_clk);
		end
		if (par_en) begin
			rxd <= (eight ? ^c : ^c[6:0]) ^ par_odd;
			repeat (div) @(posedge ref_clk);
		end
		rxd <= 1'b1;
		repeat (stop2 ? div * 2 : div) @(posedge ref_clk);
	endtask
endmodule // dmsp_host_model

`default_nettype wire

/* dv/dmsp_top_tb.sv */
// Self-checking bench for the meter serial port, host model on the link.
// Assumes a shortened bit period: 1024 clocks at selector 0.
`timescale 1ns/1ps
`default_nettype none

module dmsp_top_tb import dmsp_pkg::*; ();
	localparam int BB = 97656;
	localparam int DIV0 = 100_000_000 / BB;
	localparam dmsp_frame_t CFGS [5] = '{8'h25, 8'hD6, 8'h87, 8'h19, 8'h63};
	// Positions 8 and 9 must both give the top rate
	localparam logic [3:0] DIALS [3] = '{4'h9, 4'h2, 4'h8};
	logic ref_clk, reset, standalone_in, dtr_in, rxd, txd, cts, dsr, dcd;
	logic h_eight, h_pe, h_po, h_s2;
	logic [15:0] h_div;
	logic [3:0] baud_dial_in;
	logic [31:0] reg_rdata, v;
	logic [7:0] c, q[9];
	dmsp_req_t reg_req;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;

	dmsp_top #(.BASE_BAUD(BB)) dut_u (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .standalone_in(standalone_in), .baud_dial_in(baud_dial_in),
		.rxd_in(rxd), .txd_out(txd), .dtr_in(dtr_in), .cts_out(cts), .dsr_out(dsr), .dcd_out(dcd));
	dmsp_host_model host_u (.ref_clk(ref_clk), .div(h_div), .eight(h_eight), .par_en(h_pe),
		.par_odd(h_po), .stop2(h_s2), .txd(txd), .rxd(rxd));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] baud_div(input logic [3:0] sel);
		return 16'(DIV0 >> (sel > 4'h8 ? 8 : sel));
	endfunction

	function automatic logic [31:0] exp_frame(input logic [7:0] d);
		logic [7:0] m;
		m = h_eight ? d : {1'b0, d[6:0]};
		return {22'h0, 1'b1, h_pe & (^m ^ h_po), m};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_req <= dmsp_req_t'{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		reg_req <= '0;
	endtask

	task automatic rd(input logic [1:0] a, output logic [31:0] r);
		@(posedge ref_clk);
		reg_req <= dmsp_req_t'{1'b0, 1'b1, a, 32'h0};
		@(posedge ref_clk);
		reg_req <= '0;
		#1 r = reg_rdata;
	endtask

	task automatic host_cfg(input dmsp_frame_t f);
		h_div = baud_div(f.baud);
		{h_s2, h_po, h_pe, h_eight} = {f.stop2, f.par_odd, f.par_en, f.eight};
	endtask

	task automatic wait_rx(input int n);
		for (int k = 0; k < 20000 && host_u.rx_q.size() < n; k++) @(posedge ref_clk);
	endtask

	function automatic logic [31:0] pop();
		return {22'h0, host_u.rx_q.pop_front()};
	endfunction

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		reset = 1'b1;
		reg_req = '0;
		standalone_in = 1'b0;
		baud_dial_in = 4'h0;
		dtr_in = 1'b1;
		host_cfg(CTRL_RESET);
		void'($urandom(32'h01A6));
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		#1 chk({cts, dsr, dcd, txd}, 4'hF);
		rd(OFS_CTRL, v);
		chk(v, 32'h14);
		rd(OFS_STATUS, v);
		chk(v, 32'h22);
		$display("test reset done");
		// Host holds transmission off while the FIFO overfills
		dtr_in <= 1'b0;
		foreach (q[i]) begin
			q[i] = 8'($urandom);
			wr(OFS_TXDATA, {24'h0, q[i]});
		end
		rd(OFS_STATUS, v);
		chk(v[5:0], 6'h01);
		repeat (1000) @(posedge ref_clk);
		chk(host_u.rx_q.size(), 0);
		dtr_in <= 1'b1;
		wait_rx(8);
		for (int i = 0; i < 8; i++) chk(pop(), exp_frame(q[i]));
		repeat (1000) @(posedge ref_clk);
		chk(host_u.rx_q.size(), 0);
		$display("test fifo and dtr done");
		// Five frame shapes (7E1, 8N2, 7N2, 8N1, 7O1) in both directions, back-to-back transmit
		foreach (CFGS[i]) begin
			wr(OFS_CTRL, {24'h0, CFGS[i]});
			host_cfg(CFGS[i]);
			q[0] = 8'($urandom);
			q[1] = 8'($urandom);
			wr(OFS_TXDATA, {24'h0, q[0]});
			wr(OFS_TXDATA, {24'h0, q[1]});
			wait_rx(2);
			chk(pop(), exp_frame(q[0]));
			chk(pop(), exp_frame(q[1]));
			c = 8'h70 | 8'($urandom_range(7));
			host_u.send_char(c);
			rd(OFS_RXSET, v);
			chk(v, {23'h0, 1'b1, c});
		end
		$display("test frame formats done");
		// Standalone unit ignores the frame fields and follows the dial
		wr(OFS_CTRL, 32'hE3);
		standalone_in <= 1'b1;
		foreach (DIALS[i]) begin
			baud_dial_in <= DIALS[i];
			host_cfg(FIXED_FRAME | {4'h0, DIALS[i]});
			q[0] = 8'($urandom);
			wr(OFS_TXDATA, {24'h0, q[0]});
			wait_rx(1);
			chk(pop(), exp_frame(q[0]));
		end
		$display("test standalone done");
		standalone_in <= 1'b0;
		wr(OFS_CTRL, {24'h0, CTRL_RESET});
		host_cfg(CTRL_RESET);
		// Setting characters from both ranges are acknowledged
		for (int i = 0; i < 2; i++) begin
			c = i ? 8'h65 + 8'($urandom_range(3)) : 8'h20 + 8'($urandom_range(42));
			host_u.send_char(c);
			rd(OFS_RXSET, v);
			chk(v, {23'h0, 1'b1, c});
			rd(OFS_RXSET, v);
			chk(v, {24'h0, c});
			wait_rx(5);
			for (int k = 4; k >= 0; k--) chk(pop(), exp_frame(ACK_TEXT[k*8 +: 8]));
		end
		$display("test acknowledge done");
		// Bad parity and a missing stop bit are flagged, dropped and cleared by software
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CTRL, i ? 32'h04 : 32'h34);
			host_cfg(i ? 8'h14 : 8'h74);
			q[0] = 8'h20 + 8'($urandom_range(42));
			host_u.send_char(q[0]);
			rd(OFS_RXSET, v);
			chk(v, {24'h0, c});
			rd(OFS_STATUS, v);
			chk(v, i ? 32'h32 : 32'h2A);
			wr(OFS_STATUS, i ? 32'h10 : 32'h08);
			rd(OFS_STATUS, v);
			chk(v, 32'h22);
			repeat (800) @(posedge ref_clk);
			chk(host_u.rx_q.size(), 0);
		end
		$display("test line errors done");
		close_out();
	end
endmodule // dmsp_top_tb

`default_nettype wire
